/* bench/adcs_master.sv */
// Behavioural two-wire bus master driving the converter port
`timescale 1ns/1ps
`default_nettype none
module adcs_master
(
	input  wire logic clk,
	input  wire logic sda,
	output var  logic scl,
	output var  logic sda_pull
);
	// Idle bus: clock high and data released
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// Wait n system clocks, then step off the edge
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : hold

	// Start or repeated start: data falls while the clock is high
	task automatic start();
		sda_pull = 1'b0;
		hold(4);
		scl = 1'b1;
		hold(4);
		sda_pull = 1'b1;
		hold(4);
		scl = 1'b0;
		hold(4);
	endtask : start

	// Stop: data rises while the clock is high; the clock then stands still
	task automatic stop();
		sda_pull = 1'b1;
		hold(4);
		scl = 1'b1;
		hold(4);
		sda_pull = 1'b0;
		hold(4);
	endtask : stop

	// Eight bits and the acknowledge slot, 200 ns per bit; a 1 releases the line.
	// Sampled late in the high phase because the port answers a few clocks late.
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
		begin
			sda_pull = ~tx[i];
			hold(2);
			scl = 1'b1;
			hold(4);
			rx[i] = sda;
			scl = 1'b0;
			hold(2);
		end
	endtask : xfer
endmodule : adcs_master
`default_nettype wire

/* bench/test_adc_i2c_slave_port.sv */
// Self-checking bench for the converter's two-wire slave port
`timescale 1ns/1ps
`default_nettype none
module test_adc_i2c_slave_port import adcs_pkg::*;;
	logic        clk;
	logic        resetn;
	logic [11:0] conv_sample;
	logic        m_scl, m_pull, sda_o, sda_oe, scl_oe, conv_active, hs_mode;
	logic [1:0]  gain_sel;
	int          n_errors = 0, compares = 0, cycles = 0;
	// Both lines are open drain with pull-ups; the port pulls only with a low level
	wire logic   sda_line = ~(m_pull | (sda_oe & ~sda_o));
	wire logic   scl_line = m_scl & ~scl_oe;

	adcs_slave #(.ADDR_VARIANT(1'b0), .CONV_CYCLES(19'd1000)) adcs_slave_inst
	(
		.clk(clk), .resetn(resetn), .scl_i(scl_line), .sda_i(sda_line),
		.conv_sample(conv_sample), .sda_o(sda_o), .sda_oe(sda_oe), .scl_oe(scl_oe),
		.gain_sel(gain_sel), .conv_active(conv_active), .hs_mode(hs_mode)
	);
	adcs_master adcs_master_inst (.clk(clk), .sda(sda_line), .scl(m_scl), .sda_pull(m_pull));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Hang guard and clock-line watch
	always @(posedge clk)
	begin
		cycles++;
		if (resetn === 1'b1) check("clock drive", 0, scl_oe);
		if (cycles == 40000)
		begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check

	// Address byte then n data bytes; ack holds address, first, second
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n,
		output logic [2:0] ack);
		logic [8:0] rx;
		ack = 3'b000;
		adcs_master_inst.start();
		adcs_master_inst.xfer({a, 1'b1}, rx);
		ack[2] = ~rx[0];
		for (int i = 0; i < n; i++)
		begin
			adcs_master_inst.xfer({d[15 - 8 * i -: 8], 1'b1}, rx);
			ack[1 - i] = ~rx[0];
		end
		adcs_master_inst.stop();
	endtask : wr

	// Read n bytes, acking all but the last
	task automatic rd(input int n, output logic [31:0] v);
		logic [8:0] rx;
		v = '0;
		adcs_master_inst.start();
		adcs_master_inst.xfer({8'h91, 1'b1}, rx);
		check("read ack", 0, rx[0]);
		for (int i = 1; i <= n; i++)
		begin
			adcs_master_inst.xfer({8'hFF, i == n}, rx);
			v = {v[23:0], rx[8:1]};
		end
		adcs_master_inst.stop();
	endtask : rd

	task automatic wait_active(input logic lvl);
		for (int k = 0; k < 1200 && conv_active !== lvl; k++) @(negedge clk);
		check("converting", lvl, conv_active);
	endtask : wait_active

	task automatic t_reset();
		logic [31:0] v;
		check("gain", 0, gain_sel);
		check("fast mode", 0, hs_mode);
		rd(4, v);
		check("after reset", 32'h000080FF, v);
	endtask : t_reset

	task automatic t_address();
		logic [2:0] ack;
		wr(8'h92, 16'h1300, 1, ack);
		check("other variant", 0, ack);
		wr(8'h94, 16'h1300, 1, ack);
		check("foreign", 0, ack);
		check("gain kept", 0, gain_sel);
	endtask : t_address

	// Continuous readback, then a switch to single while converting
	task automatic t_modes();
		logic [31:0] v;
		logic [2:0] ack;
		conv_sample = 12'h7FF;
		wr(8'h90, 16'h0000, 1, ack);
		wait_active(1);
		repeat (1100) @(posedge clk);
		#1;
		rd(3, v);
		check("continuous", 32'h0007FF80, v);
		wr(8'h90, 16'h1000, 1, ack);
		check("still converting", 1, conv_active);
		wait_active(0);
		rd(3, v);
		check("after switch", 32'h0007FF10, v);
	endtask : t_modes

	task automatic t_gain();
		logic [2:0] ack;
		for (int g = 0; g < 4; g++)
		begin
			wr(8'h90, {6'h04, g[1:0], 6'h00, ~g[1:0]}, 2, ack);
			check("write acks", 3'b110, ack);
			check("gain", g, gain_sel);
			check("no start", 0, conv_active);
		end
	endtask : t_gain

	task automatic t_single();
		logic [31:0] v;
		logic [2:0] ack;
		conv_sample = 12'h800;
		wr(8'h90, 16'h9100, 1, ack);
		rd(3, v);
		check("busy", 32'h0007FF91, v);
		wait_active(0);
		rd(2, v);
		check("negative", 32'h0000F800, v);
	endtask : t_single

	task automatic t_call();
		logic [31:0] v;
		logic [2:0] ack;
		wr(8'h00, 16'h0500, 1, ack);
		check("call 05", 3'b100, ack);
		wr(8'h00, 16'h0400, 1, ack);
		check("call 04", 3'b110, ack);
		check("gain kept", 1, gain_sel);
		wr(8'h00, 16'h0600, 1, ack);
		check("call 06", 3'b110, ack);
		check("gain reset", 0, gain_sel);
		rd(3, v);
		check("after call", 32'h00000080, v);
	endtask : t_call

	task automatic t_fast();
		logic [8:0] rx;
		adcs_master_inst.start();
		adcs_master_inst.xfer({8'h09, 1'b1}, rx);
		check("code ack", 1, rx[0]);
		check("fast on", 1, hs_mode);
		adcs_master_inst.start();
		adcs_master_inst.xfer({8'h91, 1'b1}, rx);
		check("fast ack", 0, rx[0]);
		adcs_master_inst.xfer({8'hFF, 1'b1}, rx);
		adcs_master_inst.stop();
		check("fast off", 0, hs_mode);
	endtask : t_fast

	task automatic print_verdict();
		$display("n_errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	initial
	begin
		resetn = 1'b0;
		conv_sample = 12'hABC;
		repeat (8) @(posedge clk);
		#1;
		resetn = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		t_reset();
		t_address();
		t_modes();
		t_gain();
		t_single();
		t_call();
		t_fast();
		print_verdict();
	end
endmodule : test_adc_i2c_slave_port
`default_nettype wire

/* hw/adcs_map.svh */
// Constants for the converter's two-wire slave port and its registers
//
// Contract
// - Answer only the fixed 7-bit address 1001000 or 1001001, chosen by variant.
// - Acknowledge general-call address 00h and data 06h, treat as reset request.
// - That reset aborts conversion, zeroes result, restores setup default, as power-up.
// - Always acknowledge general-call address; do not acknowledge data other than 04h/06h.
// - Master code 00001XXX after start is not acknowledged; fast clocks then accepted.
// - Leave high-speed mode at the first stop after the master code.
// - Result is 12-bit two's complement, right-justified, top four bits copy sign.
// - Result reads zero after any reset until the first conversion completes.
// - Setup register takes 80h on reset.
// - Single-shot: writing 1 to bit 7 starts a conversion; continuous ignores it.
// - Single-shot: bit 7 reads 1 while converting, 0 when idle.
// - Continuous mode: bit 7 always reads 1.
// - Bit 4 selects mode: 1 single-shot, 0 continuous; reset value 0.
// - Bits 1:0 select gain 1, 2, 4 or 8; default gain 1.
// - Read returns result high byte, then low byte, then setup byte.
// - Bytes read past the third return FFh with no side effect.
// - Write loads only the first data byte, acknowledges only it.
// - Never hold the clock line low.
// - Single-shot completion stores result, clears bit 7, powers down.
// - Continuous to single-shot: finish current conversion, clear bit 7, power down.
`ifndef ADCS_MAP_SVH
`define ADCS_MAP_SVH
`define ADCS_ADDR_VAR0   7'h48
`define ADCS_ADDR_VAR1   7'h49
`define ADCS_GC_ADDR     8'h00
`define ADCS_GC_RESET    8'h06
`define ADCS_GC_LATCH    8'h04
`define ADCS_HS_CODE     5'h01
`define ADCS_CFG_RESET   8'h80
`define ADCS_RES_RESET   16'h0000
`define ADCS_FILL        8'hFF
`define ADCS_BIT_START   7
`define ADCS_BIT_SINGLE  4
`define ADCS_BIT_GAIN_HI 1
`define ADCS_BIT_GAIN_LO 0
`define ADCS_CLK_PERIOD_NS 25
`define ADCS_CONV_TIME_NS  7812500
`define ADCS_CONV_CYCLES   (`ADCS_CONV_TIME_NS / `ADCS_CLK_PERIOD_NS)
`endif

/* hw/adcs_pkg.sv */
// Types shared by the converter slave port
package adcs_pkg;
	typedef enum logic [2:0]
	{
		ADCS_IDLE = 3'h0,
		ADCS_ADDR = 3'h1,
		ADCS_RD   = 3'h3,
		ADCS_WR   = 3'h2,
		ADCS_GCD  = 3'h6
	} adcs_st_e;

	typedef struct packed
	{
		logic       single_shot_select;
		logic [1:0] gain;
	} adcs_cfg_s;
endpackage : adcs_pkg

/* hw/adcs_slave.sv */
// Two-wire slave port, setup/result registers and conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adcs_map.svh"
module adcs_slave
	import adcs_pkg::*;
#(
	parameter logic        ADDR_VARIANT = 1'b0,
	parameter logic [18:0] CONV_CYCLES  = 19'(`ADCS_CONV_CYCLES)
)
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	input  wire logic [11:0] conv_sample,
	output var  logic        sda_o,
	output var  logic        sda_oe,
	output var  logic        scl_oe,
	output var  logic [1:0]  gain_sel,
	output var  logic        conv_active,
	output var  logic        hs_mode
);
	logic       scl_s1_q, scl_s2_q, scl_s3_q;
	logic       sda_s1_q, sda_s2_q, sda_s3_q;
	logic       scl_rise, scl_fall, bus_start, bus_stop;
	logic       ack_dec, ack_end, tx_shift;
	adcs_st_e   st_q, st_d;
	logic [3:0] bit_q;
	logic [7:0] rx_q;
	logic [7:0] tx_q;
	logic [1:0] byte_q;
	logic       nack_q;
	logic       sda_oe_q, hs_q, gc_rst_q;
	logic [6:0] dev_addr;
	logic       addr_hit, gc_hit, hs_hit, gc_ok, ack_now;
	logic       rd_go, wr_cfg, start_req, conv_done;
	logic [1:0] rd_idx;
	logic [7:0] tx_byte;
	logic [7:0] cfg_rb;
	adcs_cfg_s  cfg_q;
	logic       conv_on_q;
	logic [18:0] cnt_q;
	logic [15:0] result_q, snap_q;
	localparam logic [7:0] CFG_DEFAULT = `ADCS_CFG_RESET;

	// Two flops on each pin, a third copy only for edge finding
	always_ff @(posedge clk)
	begin
		scl_s1_q <= scl_i;
		scl_s2_q <= scl_s1_q;
		scl_s3_q <= scl_s2_q;
		sda_s1_q <= sda_i;
		sda_s2_q <= sda_s1_q;
		sda_s3_q <= sda_s2_q;
	end

	// Bus events seen on the synchronised copies
	assign scl_rise  = scl_s2_q & ~scl_s3_q;
	assign scl_fall  = ~scl_s2_q & scl_s3_q;
	assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
	assign bus_stop  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
	assign ack_dec   = scl_fall & (bit_q == 4'h8);
	assign ack_end   = scl_fall & (bit_q == 4'h9);
	assign tx_shift  = scl_fall & (st_q == ADCS_RD) & (bit_q != 4'h0) & (bit_q < 4'h8);

	// Address and general-call decode on the byte just received
	assign dev_addr = ADDR_VARIANT ? `ADCS_ADDR_VAR1 : `ADCS_ADDR_VAR0;
	assign addr_hit = (st_q == ADCS_ADDR) & (rx_q[7:1] == dev_addr);
	assign gc_hit   = (st_q == ADCS_ADDR) & (rx_q == `ADCS_GC_ADDR);
	assign hs_hit   = (st_q == ADCS_ADDR) & (rx_q[7:3] == `ADCS_HS_CODE);
	assign gc_ok    = (rx_q == `ADCS_GC_RESET) | (rx_q == `ADCS_GC_LATCH);

	// Acknowledge choice; master code and later write bytes get none
	always_comb
	begin
		case (st_q)
			ADCS_ADDR: ack_now = addr_hit | gc_hit;
			ADCS_WR:   ack_now = (byte_q == 2'h0);
			ADCS_GCD:  ack_now = gc_ok;
			default:   ack_now = 1'b0;
		endcase
	end

	// Read byte order, then fill once the three bytes are spent
	assign rd_go  = ack_end & ((addr_hit & rx_q[0]) | ((st_q == ADCS_RD) & ~nack_q));
	assign rd_idx = (st_q == ADCS_ADDR) ? 2'h0 : byte_q;
	always_comb
	begin
		case (rd_idx)
			2'h0:    tx_byte = snap_q[15:8];
			2'h1:    tx_byte = snap_q[7:0];
			2'h2:    tx_byte = cfg_rb;
			default: tx_byte = `ADCS_FILL;
		endcase
	end

	// Next bus state at start, at stop and after each ninth clock
	always_comb
	begin
		st_d = st_q;
		if (bus_start)
			st_d = ADCS_ADDR;
		else if (bus_stop)
			st_d = ADCS_IDLE;
		else if (ack_end)
		begin
			case (st_q)
				ADCS_ADDR:
				begin
					if (addr_hit)
						st_d = rx_q[0] ? ADCS_RD : ADCS_WR;
					else if (gc_hit)
						st_d = ADCS_GCD;
					else
						st_d = ADCS_IDLE;
				end
				ADCS_RD: st_d = nack_q ? ADCS_IDLE : ADCS_RD;
				ADCS_WR: st_d = ADCS_WR;
				ADCS_GCD: st_d = ADCS_GCD;
				default: st_d = ADCS_IDLE;
			endcase
		end
	end

	// Bus state and bit counter
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st_q  <= ADCS_IDLE;
			bit_q <= 4'h0;
		end
		else
		begin
			st_q <= st_d;
			if (bus_start | bus_stop | ack_end)
				bit_q <= 4'h0;
			else if (scl_rise)
				bit_q <= bit_q + 4'h1;
		end
	end

	// Receive shifter and the master's acknowledge on reads.
	// The ninth bit must not shift in: the byte is decoded again at ack end.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			rx_q   <= 8'h00;
			nack_q <= 1'b0;
		end
		else if (scl_rise)
		begin
			if (bit_q < 4'h8)
				rx_q <= {rx_q[6:0], sda_s2_q};
			if (bit_q == 4'h8)
				nack_q <= sda_s2_q;
		end
	end

	// Byte index saturates so extra bytes do nothing
	always_ff @(posedge clk)
	begin
		if (!resetn)
			byte_q <= 2'h0;
		else if (ack_end & (st_q == ADCS_ADDR))
			byte_q <= {1'b0, rx_q[0]};
		else if (ack_end & (byte_q != 2'h3))
			byte_q <= byte_q + 2'h1;
	end

	// Transmit shifter; ones shift in so a released line reads high
	always_ff @(posedge clk)
	begin
		if (!resetn)
			tx_q <= `ADCS_FILL;
		else if (rd_go)
			tx_q <= tx_byte;
		else if (tx_shift)
			tx_q <= {tx_q[6:0], 1'b1};
	end

	// Data line drive: only ever pulls low, released at start and stop
	always_ff @(posedge clk)
	begin
		if (!resetn)
			sda_oe_q <= 1'b0;
		else if (bus_start | bus_stop)
			sda_oe_q <= 1'b0;
		else if (ack_dec)
			sda_oe_q <= ack_now;
		else if (ack_end)
			sda_oe_q <= rd_go & ~tx_byte[7];
		else if (tx_shift)
			sda_oe_q <= ~tx_q[6];
	end

	// Fast-mode filters on after the master code, off at the next stop
	always_ff @(posedge clk)
	begin
		if (!resetn)
			hs_q <= 1'b0;
		else if (bus_stop)
			hs_q <= 1'b0;
		else if (ack_dec & hs_hit)
			hs_q <= 1'b1;
	end

	// General-call reset request, applied one clock later
	always_ff @(posedge clk)
	begin
		if (!resetn)
			gc_rst_q <= 1'b0;
		else
			gc_rst_q <= ack_dec & (st_q == ADCS_GCD) & (rx_q == `ADCS_GC_RESET);
	end

	// Setup write takes the first data byte only; reserved bits dropped
	assign wr_cfg    = ack_dec & (st_q == ADCS_WR) & (byte_q == 2'h0);
	assign start_req = wr_cfg & rx_q[`ADCS_BIT_START] & rx_q[`ADCS_BIT_SINGLE] & ~conv_on_q;
	assign conv_done = conv_on_q & (cnt_q == CONV_CYCLES - 19'h1);

	always_ff @(posedge clk)
	begin
		if (!resetn | gc_rst_q)
		begin
			cfg_q.single_shot_select <= CFG_DEFAULT[`ADCS_BIT_SINGLE];
			cfg_q.gain <= CFG_DEFAULT[`ADCS_BIT_GAIN_HI:`ADCS_BIT_GAIN_LO];
		end
		else if (wr_cfg)
		begin
			cfg_q.single_shot_select <= rx_q[`ADCS_BIT_SINGLE];
			cfg_q.gain <= rx_q[`ADCS_BIT_GAIN_HI:`ADCS_BIT_GAIN_LO];
		end
	end

	// Busy bit reads 1 in continuous mode, else follows the converter
	assign cfg_rb = {~cfg_q.single_shot_select | conv_on_q, 2'h0,
		cfg_q.single_shot_select, 2'h0, cfg_q.gain};

	// Conversion sequencer; a mode change lets the running one finish
	always_ff @(posedge clk)
	begin
		if (!resetn | gc_rst_q)
		begin
			conv_on_q <= 1'b0;
			cnt_q     <= 19'h0;
		end
		else if (conv_done)
		begin
			conv_on_q <= ~cfg_q.single_shot_select;
			cnt_q     <= 19'h0;
		end
		else
		begin
			if (~cfg_q.single_shot_select | start_req)
				conv_on_q <= 1'b1;
			if (conv_on_q)
				cnt_q <= cnt_q + 19'h1;
		end
	end

	// Whole word loads in one clock; reads use a copy taken at address time
	always_ff @(posedge clk)
	begin
		if (!resetn | gc_rst_q)
			result_q <= `ADCS_RES_RESET;
		else if (conv_done)
			result_q <= {{4{conv_sample[11]}}, conv_sample};
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			snap_q <= `ADCS_RES_RESET;
		else if (ack_dec & addr_hit & rx_q[0])
			snap_q <= result_q;
	end

	// Pin and status outputs; clock line is never driven
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			sda_o       <= 1'b0;
			sda_oe      <= 1'b0;
			scl_oe      <= 1'b0;
			gain_sel    <= 2'h0;
			conv_active <= 1'b0;
			hs_mode     <= 1'b0;
		end
		else
		begin
			sda_o       <= 1'b0;
			sda_oe      <= sda_oe_q;
			scl_oe      <= 1'b0;
			gain_sel    <= cfg_q.gain;
			conv_active <= conv_on_q;
			hs_mode     <= hs_q;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_gc_reset;
		gc_rst_q |=> (cfg_rb == `ADCS_CFG_RESET) && (result_q == 16'h0000) && !conv_on_q;
	endproperty
	a_gc_reset: assert property (p_gc_reset) else $error("gc reset not applied");

	property p_gc_ack;
		ack_dec && (st_q == ADCS_GCD) && (rx_q == `ADCS_GC_RESET) |=> sda_oe_q && gc_rst_q;
	endproperty
	a_gc_ack: assert property (p_gc_ack) else $error("gc reset byte not acked");

	property p_gc_nack;
		ack_dec && (st_q == ADCS_GCD) && !gc_ok |=> !sda_oe_q;
	endproperty
	a_gc_nack: assert property (p_gc_nack) else $error("bad gc byte acked");

	property p_hs_entry;
		ack_dec && hs_hit |=> !sda_oe_q && hs_q;
	endproperty
	a_hs_entry: assert property (p_hs_entry) else $error("master code handling wrong");

	property p_hs_exit;
		bus_stop |=> !hs_q ##2 !hs_mode;
	endproperty
	a_hs_exit: assert property (p_hs_exit) else $error("hs mode kept after stop");

	property p_sign;
		result_q[15:12] == {4{result_q[11]}};
	endproperty
	a_sign: assert property (p_sign) else $error("result not sign extended");

	property p_cont_busy;
		!cfg_q.single_shot_select |-> cfg_rb[7];
	endproperty
	a_cont_busy: assert property (p_cont_busy) else $error("continuous busy low");

	property p_single_done;
		conv_done && cfg_q.single_shot_select |=> !conv_on_q && !cfg_rb[7];
	endproperty
	a_single_done: assert property (p_single_done) else $error("single shot kept busy");

	property p_fill;
		rd_go && (st_q == ADCS_RD) && (byte_q == 2'h3) |=> tx_q == `ADCS_FILL;
	endproperty
	a_fill: assert property (p_fill) else $error("extra read byte not FF");

	property p_wr_extra;
		ack_dec && (st_q == ADCS_WR) && (byte_q != 2'h0) |=> !sda_oe_q ##2 !sda_oe;
	endproperty
	a_wr_extra: assert property (p_wr_extra) else $error("extra write byte acked");

	property p_no_stretch;
		scl_rise |-> ##[1:3] !scl_oe;
	endproperty
	a_no_stretch: assert property (p_no_stretch) else $error("clock line driven");
endmodule : adcs_slave
`default_nettype wire
